// >>> src/sfr_device.sv
/*
 * Device end of the serial flash read engine: frames commands under chip
 * select, decodes read opcodes, streams array, page, buffer and status data.
 * Assumes the array is served outside on arrayAddr/arrayData within half a
 * serial clock, and buffers are loaded over the ref_clk write port.
 */
`timescale 1ns/1ps
// How it works
// - chip select falls, 8-bit opcode, then address
// - everything shifts most significant bit first
// - page 13 bits, byte 10 bits, buffer 10
// - 68H/E8H: 24 address, 32 dummy bits
// - skip reserved bit, then page, then byte
// - one data bit per clock after dummies
// - continuous read advances across pages seamlessly
// - end of array wraps to first page
// - chip select rise ends read, releases output
// - host keeps chip select low whole command
// - main reads leave both buffers untouched
// - 52H/D2H: 24 address, 32 dummy bits
// - page read wraps within same page
// - buffer read: 14 dummy, 10 address, 8 dummy
// - 528-byte buffers wrap to first byte
// - 57H/D7H streams status, bit 7 first
// - upper six bits info, lower two reserved
// - status repeats, refreshed each byte
// - opcode bit 7, not the pair, selects clock category
// - works in SPI mode 0 and 3
// - status bit 7 one means ready
module sfr_device #(
	parameter int PAGE_BYTES = sfr_pkg::PAGE_BYTES,
	parameter int BUF_BYTES = sfr_pkg::BUF_BYTES
) (
	// system side
	input wire logic ref_clk,
	input wire logic arst_n,
	// serial link
	sfr_link_if.dev lnk,
	// buffer load port, ref_clk domain
	input wire logic bufWrEn,
	input wire logic bufWrSel,
	input wire logic [9:0] bufWrAddr,
	input wire logic [7:0] bufWrData,
	// device state, ref_clk domain levels
	input wire logic deviceReady,
	input wire logic compareMismatch,
	// array read port, serial clock domain
	output logic [22:0] arrayAddr,
	input wire logic [7:0] arrayData,
	// activity, ref_clk domain
	output logic readActive,
	output logic highCategory
);

	if (PAGE_BYTES < 2 || PAGE_BYTES > 1024) begin : g_page_chk
		$error("PAGE_BYTES must fit a 10-bit byte address");
	end
	if (BUF_BYTES < 2 || BUF_BYTES > 1024) begin : g_buf_chk
		$error("BUF_BYTES must fit a 10-bit byte address");
	end

	localparam logic [9:0] PAGE_LAST = 10'(PAGE_BYTES - 1);
	localparam logic [9:0] BUF_LAST = 10'(BUF_BYTES - 1);

	// link logic except opCategory is held in reset whenever chip select is high
	logic linkRst_n;
	assign linkRst_n = arst_n & ~lnk.csN;

	// rising-edge side: command capture
	logic [6:0] bitCount;
	logic [31:0] shiftIn;
	logic [31:0] next_shiftIn;
	logic [7:0] opcode;
	logic [12:0] startPage;
	logic [9:0] startByte;

	assign next_shiftIn = {shiftIn[30:0], lnk.si};

	// mode 0 and 3 both sample on the rising edge, so idle level does not matter
	always_ff @(posedge lnk.sck or negedge linkRst_n) begin
		if (!linkRst_n) begin
			bitCount <= 7'h00;
			shiftIn <= 32'h0000_0000;
		end else begin
			shiftIn <= next_shiftIn;
			if (bitCount != sfr_pkg::BIT_COUNT_SAT) begin
				bitCount <= bitCount + 7'h01;
			end
		end
	end

	always_ff @(posedge lnk.sck or negedge linkRst_n) begin
		if (!linkRst_n) begin
			opcode <= 8'h00;
		end else if (bitCount == 7'(sfr_pkg::OPC_BITS - 1)) begin
			opcode <= next_shiftIn[7:0];
		end
	end

	// category outlives the frame, opcode does not; the system side reads it after chip select rises
	logic opCategory;
	always_ff @(posedge lnk.sck or negedge arst_n) begin
		if (!arst_n) begin
			opCategory <= 1'b0;
		end else if (bitCount == 7'(sfr_pkg::OPC_BITS - 1)) begin
			opCategory <= next_shiftIn[sfr_pkg::OP_CATEGORY_BIT];
		end
	end

	// reserved bit 23 dropped; buffer reads reuse the low ten bits
	always_ff @(posedge lnk.sck or negedge linkRst_n) begin
		if (!linkRst_n) begin
			startPage <= 13'h0000;
			startByte <= 10'h000;
		end else if (bitCount == 7'(sfr_pkg::ADDR_END - 1)) begin
			startPage <= next_shiftIn[22:10];
			startByte <= next_shiftIn[9:0];
		end
	end

	// opcode decode; both members of a pair map to one kind
	sfr_pkg::sfr_kind_type kind;
	logic [6:0] dataStart;
	logic dataPhase;

	always_comb begin
		case (opcode)
			sfr_pkg::OP_ARRAY_LO, sfr_pkg::OP_ARRAY_HI: kind = sfr_pkg::KIND_ARRAY;
			sfr_pkg::OP_PAGE_LO, sfr_pkg::OP_PAGE_HI: kind = sfr_pkg::KIND_PAGE;
			sfr_pkg::OP_BUF1_LO, sfr_pkg::OP_BUF1_HI: kind = sfr_pkg::KIND_BUF1;
			sfr_pkg::OP_BUF2_LO, sfr_pkg::OP_BUF2_HI: kind = sfr_pkg::KIND_BUF2;
			sfr_pkg::OP_STATUS_LO, sfr_pkg::OP_STATUS_HI: kind = sfr_pkg::KIND_STATUS;
			default: kind = sfr_pkg::KIND_NONE;
		endcase
	end

	always_comb begin
		case (kind)
			sfr_pkg::KIND_ARRAY, sfr_pkg::KIND_PAGE: dataStart = 7'(sfr_pkg::MAIN_DATA_START);
			sfr_pkg::KIND_BUF1, sfr_pkg::KIND_BUF2: dataStart = 7'(sfr_pkg::BUF_DATA_START);
			sfr_pkg::KIND_STATUS: dataStart = 7'(sfr_pkg::STATUS_DATA_START);
			default: dataStart = sfr_pkg::BIT_COUNT_SAT;
		endcase
	end

	// unknown opcodes never reach the data phase
	assign dataPhase = (kind != sfr_pkg::KIND_NONE) && (bitCount >= dataStart);

	// status synchronisers, serial clock domain
	logic readyMeta;
	logic readySync;
	logic compareMeta;
	logic compareSync;

	always_ff @(posedge lnk.sck or negedge linkRst_n) begin
		if (!linkRst_n) begin
			readyMeta <= 1'b0;
			readySync <= 1'b0;
			compareMeta <= 1'b0;
			compareSync <= 1'b0;
		end else begin
			readyMeta <= deviceReady;
			readySync <= readyMeta;
			compareMeta <= compareMismatch;
			compareSync <= compareMeta;
		end
	end

	logic [7:0] statusByte;
	assign statusByte = {readySync, compareSync, sfr_pkg::ST_DENSITY, sfr_pkg::ST_RESERVED};

	// buffer storage; written on ref_clk, read on the serial clock
	logic [7:0] bufMem [0:2*BUF_BYTES-1];
	logic [10:0] bufRdIdx;
	logic [9:0] curByte;
	logic [12:0] curPage;

	always_ff @(posedge ref_clk) begin
		if (bufWrEn && bufWrAddr <= BUF_LAST) begin
			bufMem[bufWrSel ? 11'(BUF_BYTES) + 11'(bufWrAddr) : 11'(bufWrAddr)] <= bufWrData;
		end
	end

	assign bufRdIdx = (kind == sfr_pkg::KIND_BUF2) ? 11'(BUF_BYTES) + 11'(curByte) : 11'(curByte);

	// source byte for the next output byte
	logic [7:0] srcByte;
	always_comb begin
		case (kind)
			sfr_pkg::KIND_ARRAY, sfr_pkg::KIND_PAGE: srcByte = arrayData;
			sfr_pkg::KIND_BUF1, sfr_pkg::KIND_BUF2: srcByte = bufMem[bufRdIdx];
			sfr_pkg::KIND_STATUS: srcByte = statusByte;
			default: srcByte = 8'h00;
		endcase
	end

	// falling-edge side: output shifter and address counter
	logic [2:0] bitSel;
	logic [7:0] outByte;
	logic [9:0] lastByte;
	logic so;
	logic soEn;

	assign lastByte = (kind == sfr_pkg::KIND_BUF1 || kind == sfr_pkg::KIND_BUF2) ? BUF_LAST : PAGE_LAST;

	always_ff @(negedge lnk.sck or negedge linkRst_n) begin
		if (!linkRst_n) begin
			so <= 1'b0;
			soEn <= 1'b0;
			bitSel <= 3'h0;
			outByte <= 8'h00;
			curPage <= 13'h0000;
			curByte <= 10'h000;
		end else if (!dataPhase) begin
			curPage <= startPage;
			curByte <= startByte;
			bitSel <= 3'h0;
		end else begin
			soEn <= 1'b1;
			bitSel <= bitSel + 3'h1;
			if (bitSel == 3'h0) begin
				so <= srcByte[7];
				outByte <= {srcByte[6:0], 1'b0};
				if (curByte >= lastByte) begin
					curByte <= 10'h000;
					if (kind == sfr_pkg::KIND_ARRAY) begin
						curPage <= curPage + 13'h0001;
					end
				end else begin
					curByte <= curByte + 10'h001;
				end
			end else begin
				so <= outByte[7];
				outByte <= {outByte[6:0], 1'b0};
			end
		end
	end

	assign lnk.so = so;
	assign lnk.soEn = soEn;
	assign arrayAddr = {curPage, curByte};

	// activity and opcode category back to ref_clk
	logic activeMeta;
	logic categoryMeta;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			activeMeta <= 1'b0;
			readActive <= 1'b0;
			categoryMeta <= 1'b0;
			highCategory <= 1'b0;
		end else begin
			activeMeta <= soEn;
			readActive <= activeMeta;
			categoryMeta <= opCategory;
			highCategory <= categoryMeta;
		end
	end

endmodule : sfr_device

// >>> src/sfr_host.sv
/*
 * Host end: SPI mode 0 master that frames one read command, sends opcode,
 * address and dummy bits, then collects a number of data bytes.
 * Assumes the device releases data out on its falling edge; serial clock
 * is divided from ref_clk.
 */
`timescale 1ns/1ps
module sfr_host #(
	parameter int HALF_PERIOD = sfr_pkg::HOST_HALF_PERIOD
) (
	// system side
	input wire logic ref_clk,
	input wire logic arst_n,
	// serial link
	sfr_link_if.host lnk,
	// command port
	input wire logic cmdStart,
	input wire logic [7:0] cmdOpcode,
	input wire logic [23:0] cmdAddr,
	input wire logic [5:0] cmdHeadBits,
	input wire logic [15:0] cmdBytes,
	// answer port
	output logic busy,
	output logic rdValid,
	output logic [7:0] rdData,
	output logic done
);

	if (HALF_PERIOD < sfr_pkg::HOST_HALF_MIN) begin : g_half_chk
		$error("HALF_PERIOD too short for the data-in synchroniser");
	end

	sfr_pkg::sfr_host_state_type state;
	logic [7:0] divCount;
	logic [63:0] header;
	logic [19:0] bitCount;
	logic [19:0] totalBits;
	logic [19:0] headEnd;
	logic [2:0] rxBits;
	logic [7:0] rxByte;
	logic soMeta;
	logic soSync;
	logic csN;
	logic sck;
	logic si;
	logic tick;

	assign tick = (divCount == 8'(HALF_PERIOD - 1));

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			soMeta <= 1'b1;
			soSync <= 1'b1;
		end else begin
			soMeta <= lnk.soLine;
			soSync <= soMeta;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			divCount <= 8'h00;
		end else if (state == sfr_pkg::HST_IDLE || tick) begin
			divCount <= 8'h00;
		end else begin
			divCount <= divCount + 8'h01;
		end
	end

	// chip select stays low from opcode to last data bit
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= sfr_pkg::HST_IDLE;
			csN <= 1'b1;
			sck <= 1'b0;
			si <= 1'b0;
			header <= 64'h0;
			bitCount <= 20'h00000;
			totalBits <= 20'h00000;
			headEnd <= 20'h00000;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				sfr_pkg::HST_IDLE: begin
					if (cmdStart) begin
						header <= {cmdOpcode, cmdAddr, 32'h0} << 1;
						si <= cmdOpcode[7];
						headEnd <= 20'(sfr_pkg::OPC_BITS) + 20'(cmdHeadBits);
						totalBits <= 20'(sfr_pkg::OPC_BITS) + 20'(cmdHeadBits) + {1'b0, cmdBytes, 3'h0};
						bitCount <= 20'h00000;
						csN <= 1'b0;
						sck <= 1'b0;
						busy <= 1'b1;
						state <= sfr_pkg::HST_SHIFT;
					end
				end
				sfr_pkg::HST_SHIFT: begin
					if (tick) begin
						if (!sck) begin
							sck <= 1'b1;
							bitCount <= bitCount + 20'h00001;
						end else if (bitCount == totalBits) begin
							sck <= 1'b0;
							csN <= 1'b1;
							state <= sfr_pkg::HST_GAP;
						end else begin
							sck <= 1'b0;
							si <= header[63];
							header <= {header[62:0], 1'b0};
						end
					end
				end
				sfr_pkg::HST_GAP: begin
					if (tick) begin
						busy <= 1'b0;
						done <= 1'b1;
						state <= sfr_pkg::HST_IDLE;
					end
				end
				default: state <= sfr_pkg::HST_IDLE;
			endcase
		end
	end

	// data bits are taken just before each rising edge, MSB first
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxBits <= 3'h0;
			rxByte <= 8'h00;
			rdData <= 8'h00;
			rdValid <= 1'b0;
		end else begin
			rdValid <= 1'b0;
			if (state == sfr_pkg::HST_IDLE) begin
				rxBits <= 3'h0;
			end else if (state == sfr_pkg::HST_SHIFT && tick && !sck && bitCount >= headEnd) begin
				rxByte <= {rxByte[6:0], soSync};
				rxBits <= rxBits + 3'h1;
				if (rxBits == 3'h7) begin
					rdData <= {rxByte[6:0], soSync};
					rdValid <= 1'b1;
				end
			end
		end
	end

	assign lnk.csN = csN;
	assign lnk.sck = sck;
	assign lnk.si = si;

endmodule : sfr_host

// >>> src/sfr_link_if.sv
/*
 * Serial link between host and flash read engine: chip select, clock, data in,
 * data out with its enable.
 * Assumes a pull-up on the data out wire; the bench reads soLine.
 */
`timescale 1ns/1ps
interface sfr_link_if;
	logic csN;
	logic sck;
	logic si;
	logic so;
	logic soEn;
	logic soLine;

	// released wire floats high through the pull-up
	assign soLine = soEn ? so : 1'b1;

	modport dev (
		input csN,
		input sck,
		input si,
		output so,
		output soEn
	);

	modport host (
		output csN,
		output sck,
		output si,
		input soLine
	);
endinterface : sfr_link_if

// >>> src/sfr_pkg.sv
/*
 * Shared constants for the serial flash read command engine: opcodes, frame
 * bit counts, memory geometry and status byte layout.
 * Assumes both ends and the bench compile this package first.
 */
package sfr_pkg;

	// geometry
	localparam int PAGE_BYTES = 528;
	localparam int PAGE_COUNT = 8192;
	localparam int BUF_BYTES = 528;
	localparam int PAGE_ADDR_BITS = 13;
	localparam int BYTE_ADDR_BITS = 10;

	// frame layout, counted in serial clock rising edges
	localparam int OPC_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam int MAIN_DUMMY_BITS = 32;
	localparam int BUF_LEAD_BITS = 14;
	localparam int BUF_DUMMY_BITS = 8;
	localparam int ADDR_END = OPC_BITS + ADDR_BITS;
	localparam int MAIN_DATA_START = ADDR_END + MAIN_DUMMY_BITS;
	localparam int BUF_DATA_START = OPC_BITS + BUF_LEAD_BITS + BYTE_ADDR_BITS + BUF_DUMMY_BITS;
	localparam int STATUS_DATA_START = OPC_BITS;
	localparam logic [6:0] BIT_COUNT_SAT = 7'h40;

	// read opcodes, low and high member of each pair
	localparam logic [7:0] OP_ARRAY_LO = 8'h68;
	localparam logic [7:0] OP_ARRAY_HI = 8'hE8;
	localparam logic [7:0] OP_PAGE_LO = 8'h52;
	localparam logic [7:0] OP_PAGE_HI = 8'hD2;
	localparam logic [7:0] OP_BUF1_LO = 8'h54;
	localparam logic [7:0] OP_BUF1_HI = 8'hD4;
	localparam logic [7:0] OP_BUF2_LO = 8'h56;
	localparam logic [7:0] OP_BUF2_HI = 8'hD6;
	localparam logic [7:0] OP_STATUS_LO = 8'h57;
	localparam logic [7:0] OP_STATUS_HI = 8'hD7;
	localparam int OP_CATEGORY_BIT = 7;

	// status byte: ready, compare, density code, reserved
	localparam int ST_READY_BIT = 7;
	localparam int ST_COMPARE_BIT = 6;
	localparam logic [3:0] ST_DENSITY = 4'hD;
	localparam logic [1:0] ST_RESERVED = 2'h0;

	// host clock divider default: half period of the serial clock in ref_clk cycles
	localparam int HOST_HALF_PERIOD = 4;
	localparam int HOST_HALF_MIN = 3;

	typedef enum logic [5:0] {
		KIND_NONE = 6'b000001,
		KIND_ARRAY = 6'b000010,
		KIND_PAGE = 6'b000100,
		KIND_BUF1 = 6'b001000,
		KIND_BUF2 = 6'b010000,
		KIND_STATUS = 6'b100000
	} sfr_kind_type;

	typedef enum logic [2:0] {
		HST_IDLE = 3'b001,
		HST_SHIFT = 3'b010,
		HST_GAP = 3'b100
	} sfr_host_state_type;

endpackage : sfr_pkg

// >>> test/sfr_link_sva.sv
/*
 * Checker for the host-to-device serial link: frame timing and release of data out.
 * Assumes it is instantiated beside the link that joins host and device.
 */
`timescale 1ns/1ps
module sfr_link_sva (
	// clocks and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// link
	input wire logic csN,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic soEn,
	input wire logic soLine
);
	localparam logic [7:0] DENS = 8'h34;
	logic [11:0] bitCnt;
	logic [7:0] opReg;
	logic isMain;
	logic isBuf;
	logic isStat;

	// cleared by chip select the same way the device clears its frame
	always_ff @(posedge sck or posedge csN or negedge arst_n) begin
		if (!arst_n) begin
			bitCnt <= 12'h000;
			opReg <= 8'h00;
		end else if (csN) begin
			bitCnt <= 12'h000;
			opReg <= 8'h00;
		end else begin
			if (bitCnt != 12'hFFF) bitCnt <= bitCnt + 12'h001;
			if (bitCnt < 12'h008) opReg <= {opReg[6:0], si};
		end
	end
	// the two opcodes of a pair differ only in bit 7
	assign isMain = opReg[6:0] == 7'h68 || opReg[6:0] == 7'h52;
	assign isBuf = opReg[6:0] == 7'h54 || opReg[6:0] == 7'h56;
	assign isStat = opReg[6:0] == 7'h57;

	release_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n) csN |-> !soEn && soLine)
		else $error("data out driven while deselected");
	en_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n) $fell(soEn) |-> csN)
		else $error("data out released inside a frame");
	sck_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n) csN |-> !sck)
		else $error("serial clock not idle low between frames");
	so_edge_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		soEn && $past(soEn) && $changed(so) |-> !sck)
		else $error("data out changed while serial clock high");
	main_quiet_a: assert property (@(posedge sck) disable iff (!arst_n || csN)
		isMain && bitCnt >= 12'h008 && bitCnt < 12'h040 |-> !soEn)
		else $error("main read data before dummy bits ended");
	main_start_a: assert property (@(posedge sck) disable iff (!arst_n || csN)
		isMain && bitCnt == 12'h040 |-> soEn ##1 soEn)
		else $error("main read data late");
	buf_quiet_a: assert property (@(posedge sck) disable iff (!arst_n || csN)
		isBuf && bitCnt >= 12'h008 && bitCnt < 12'h028 |-> !soEn)
		else $error("buffer read data early");
	buf_start_a: assert property (@(posedge sck) disable iff (!arst_n || csN)
		isBuf && bitCnt == 12'h028 |-> soEn)
		else $error("buffer read data late");
	stat_start_a: assert property (@(posedge sck) disable iff (!arst_n || csN)
		isStat && bitCnt == 12'h008 |-> soEn)
		else $error("status not out after opcode");
	stat_bits_a: assert property (@(posedge sck) disable iff (!arst_n || csN)
		isStat && bitCnt >= 12'h008 && bitCnt[2:0] >= 3'h2 |-> so == DENS[3'h7 - bitCnt[2:0]])
		else $error("status density bits wrong");
	bad_op_a: assert property (@(posedge sck) disable iff (!arst_n || csN)
		!(isMain || isBuf || isStat) && bitCnt >= 12'h008 |-> !soEn)
		else $error("data out driven for unknown opcode");
endmodule : sfr_link_sva

// >>> test/test_serial_flash_read_command_engine.sv
/*
 * Bench: host and device on one link, plus a second device driven in mode 3.
 * Assumes the package and the link interface are compiled first.
 */
`timescale 1ns/1ps
module test_serial_flash_read_command_engine;
	logic ref_clk, arst_n, cmdStart, bufWrEn, bufWrSel, deviceReady, compareMismatch;
	logic busy, rdValid, done, readActive, highCategory;
	logic [9:0] bufWrAddr;
	logic [7:0] bufWrData, cmdOpcode, rdData, rnd, got;
	logic [23:0] cmdAddr;
	logic [5:0] cmdHeadBits;
	logic [15:0] cmdBytes;
	logic [22:0] arrayAddr, arrayAddr2;
	logic [7:0] bufMod [2][528];
	logic [7:0] bufOps [4] = '{8'h54, 8'hD4, 8'h56, 8'hD6};
	logic [7:0] expQ [$];
	int mismatches, check_count;
	sfr_link_if lnk ();
	sfr_link_if lnk2 ();

	function automatic logic [7:0] memByte(input logic [22:0] a);
		return a[7:0] ^ a[17:10] ^ {3'h0, a[22:18]};
	endfunction : memByte

	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr

	sfr_device sfr_device_inst (.ref_clk(ref_clk), .arst_n(arst_n), .lnk(lnk.dev), .bufWrEn(bufWrEn),
		.bufWrSel(bufWrSel), .bufWrAddr(bufWrAddr), .bufWrData(bufWrData), .deviceReady(deviceReady),
		.compareMismatch(compareMismatch), .arrayAddr(arrayAddr), .arrayData(memByte(arrayAddr)),
		.readActive(readActive), .highCategory(highCategory));
	sfr_device sfr_device_inst2 (.ref_clk(ref_clk), .arst_n(arst_n), .lnk(lnk2.dev), .bufWrEn(bufWrEn),
		.bufWrSel(bufWrSel), .bufWrAddr(bufWrAddr), .bufWrData(bufWrData), .deviceReady(deviceReady),
		.compareMismatch(compareMismatch), .arrayAddr(arrayAddr2), .arrayData(memByte(arrayAddr2)),
		.readActive(), .highCategory());
	sfr_host sfr_host_inst (.ref_clk(ref_clk), .arst_n(arst_n), .lnk(lnk.host), .cmdStart(cmdStart),
		.cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .cmdHeadBits(cmdHeadBits), .cmdBytes(cmdBytes),
		.busy(busy), .rdValid(rdValid), .rdData(rdData), .done(done));
	sfr_link_sva sfr_link_sva_inst (.ref_clk(ref_clk), .arst_n(arst_n), .csN(lnk.csN), .sck(lnk.sck),
		.si(lnk.si), .so(lnk.so), .soEn(lnk.soEn), .soLine(lnk.soLine));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	task automatic runCmd(input string name, input logic [7:0] op, input logic [23:0] addr,
		input logic [5:0] head, input int n, input logic act);
		int guard;
		logic sawAct;
		@(negedge ref_clk);
		cmdOpcode = op;
		cmdAddr = addr;
		cmdHeadBits = head;
		cmdBytes = 16'(n);
		cmdStart = 1'b1;
		@(negedge ref_clk);
		cmdStart = 1'b0;
		guard = 0;
		sawAct = 1'b0;
		while (done !== 1'b1) begin
			@(posedge ref_clk);
			#1;
			if (readActive === 1'b1) sawAct = 1'b1;
			if (rdValid === 1'b1) check({name, " byte"}, expQ.pop_front(), rdData);
			guard++;
			if (guard > 30000) begin
				mismatches++;
				$display("[FAIL] %s expected done seen timeout", name);
				finish_test();
			end
		end
		check({name, " left"}, 8'h00, 8'(expQ.size()));
		check({name, " category"}, {7'h00, op[7]}, {7'h00, highCategory});
		check({name, " activity"}, {6'h00, act, 1'b0}, {6'h00, sawAct, readActive});
		$display("test %s done", name);
	endtask : runCmd

	// expected main bytes; page wrap keeps the page, array wrap moves on
	task automatic pushMain(input int page, input int b, input int n, input bit samePage);
		repeat (n) begin
			expQ.push_back(memByte({13'(page), 10'(b)}));
			b++;
			if (b == sfr_pkg::PAGE_BYTES) begin
				b = 0;
				if (!samePage) page = (page + 1) % sfr_pkg::PAGE_COUNT;
			end
		end
	endtask : pushMain

	initial begin
		int b;
		mismatches = 0;
		check_count = 0;
		arst_n = 1'b0;
		cmdStart = 1'b0;
		cmdOpcode = 8'h00;
		cmdAddr = 24'h000000;
		cmdHeadBits = 6'h00;
		cmdBytes = 16'h0000;
		bufWrEn = 1'b0;
		bufWrSel = 1'b0;
		bufWrAddr = 10'h000;
		bufWrData = 8'h00;
		deviceReady = 1'b1;
		compareMismatch = 1'b0;
		rnd = 8'h35;
		lnk2.csN = 1'b1;
		lnk2.sck = 1'b1;
		lnk2.si = 1'b0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		arst_n = 1'b1;
		for (int i = 0; i < 1056; i++) begin
			@(negedge ref_clk);
			rnd = lfsr(rnd);
			bufWrEn = 1'b1;
			bufWrSel = i[0];
			bufWrAddr = 10'(i / 2);
			bufWrData = rnd;
			bufMod[i % 2][i / 2] = rnd;
		end
		@(negedge ref_clk);
		bufWrEn = 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(negedge ref_clk);
			deviceReady = i[0];
			compareMismatch = i[1];
			repeat (3) expQ.push_back({i[0], i[1], sfr_pkg::ST_DENSITY, 2'h0});
			runCmd("status", i[0] ? 8'hD7 : 8'h57, 24'h000000, 6'h00, 3, 1'b1);
		end
		pushMain(8191, 520, 16, 1'b0);
		runCmd("array end", 8'hE8, {1'b1, 13'h1FFF, 10'h208}, 6'h38, 16, 1'b1);
		pushMain(5, 525, 6, 1'b0);
		runCmd("array cross", 8'h68, {1'b0, 13'h0005, 10'h20D}, 6'h38, 6, 1'b1);
		pushMain(100, 524, 8, 1'b1);
		runCmd("page wrap", 8'hD2, {1'b0, 13'h0064, 10'h20C}, 6'h38, 8, 1'b1);
		pushMain(8191, 526, 4, 1'b1);
		runCmd("page low", 8'h52, {1'b0, 13'h1FFF, 10'h20E}, 6'h38, 4, 1'b1);
		for (int k = 0; k < 4; k++) begin
			b = 522 + k;
			repeat (8) begin
				expQ.push_back(bufMod[k / 2][b]);
				b = (b + 1) % sfr_pkg::BUF_BYTES;
			end
			runCmd("buffer", bufOps[k], {14'h0000, 10'(522 + k)}, 6'h20, 8, 1'b1);
		end
		repeat (2) expQ.push_back(8'hFF);
		runCmd("unknown", 8'h84, 24'h000000, 6'h38, 2, 1'b0);
		// second link: clock idles high, frame cut short mid byte
		got = 8'h00;
		lnk2.csN = 1'b0;
		for (int i = 0; i < 16; i++) begin
			#6 lnk2.sck = 1'b0;
			if (i < 8) lnk2.si = bufOps[1][7 - i] | bufOps[3][7 - i] | (i == 7);
			#6 lnk2.sck = 1'b1;
			if (i >= 8) got[15 - i] = lnk2.soLine;
		end
		check("mode3 status", {2'h3, sfr_pkg::ST_DENSITY, 2'h0}, {got[7:2], 2'h0});
		#6 lnk2.sck = 1'b0;
		#3 check("abort driving", 8'h01, {7'h00, lnk2.soEn});
		lnk2.csN = 1'b1;
		#1 check("abort release", 8'h01, {6'h00, lnk2.soEn, lnk2.soLine});
		#2 lnk2.sck = 1'b1;
		$display("test mode3 done");
		finish_test();
	end
endmodule : test_serial_flash_read_command_engine
